// ==== bts_top.sv ====
// transfer scheme control logic for incomer or bus-tie unit with apb setup
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module bts_top #(
  parameter int MS_CYCLES = bts_pkg::MS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] pins_in,
  output logic             trip_out,
  output logic             close_out,
  output logic             out3,
  output logic             out4,
  output logic             out5,
  output logic             out6,
  output logic             out7,
  output logic             not_ready
);
  bts_in_if pin_if ();
  assign pin_if.raw = pins_in;
  bts_sync u_sync (
    .clock (clock),
    .srst  (srst),
    .pins  (pin_if.syncer)
  );

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  // synchronised inputs by name
  logic [bts_pkg::NIN-1:0] s;
  logic [bts_pkg::NIN-1:0] prev_q;
  assign s = pin_if.sync;
  wire lockout  = s[bts_pkg::IN_LOCKOUT];
  wire srctrip  = s[bts_pkg::IN_SRCTRIP];
  wire blkxfer  = s[bts_pkg::IN_BLKXFER];
  wire seltrip  = s[bts_pkg::IN_SELTRIP];
  wire brk_cls  = s[bts_pkg::IN_BRKCLOSED];
  wire srcdead  = s[bts_pkg::IN_SRCDEAD];
  wire buslive  = s[bts_pkg::IN_BUSLIVE];
  wire linelive = s[bts_pkg::IN_LINELIVE];
  wire syncok   = s[bts_pkg::IN_SYNCOK];
  wire peeruv   = s[bts_pkg::IN_PEERUV];
  wire peerblk  = s[bts_pkg::IN_PEERBLK];
  wire peercls  = s[bts_pkg::IN_PEERCLS];
  wire ropen_p  = rise(s[bts_pkg::IN_ROPEN], prev_q[bts_pkg::IN_ROPEN]);
  wire rclose_p = rise(s[bts_pkg::IN_RCLOSE], prev_q[bts_pkg::IN_RCLOSE]);
  wire req1_p   = rise(s[bts_pkg::IN_REQ1], prev_q[bts_pkg::IN_REQ1]);
  wire req2_p   = rise(s[bts_pkg::IN_REQ2], prev_q[bts_pkg::IN_REQ2]);

  // apb register file
  logic [1:0]  role_q;
  logic        blkdbl_q;
  logic [15:0] xdly_q;
  logic [15:0] uvdly_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] status_w;

  // address decode and read mux
  wire setup_w  = psel & ~penable;
  wire access_w = psel & penable & pready_q;
  wire hit_ctrl = (paddr == bts_pkg::CTRL_OFS);
  wire hit_xdly = (paddr == bts_pkg::XDLY_OFS);
  wire hit_uvd  = (paddr == bts_pkg::UVDLY_OFS);
  wire hit_stat = (paddr == bts_pkg::STATUS_OFS);
  wire mapped_w = hit_ctrl | hit_xdly | hit_uvd | hit_stat;
  wire [31:0] rd_w = hit_ctrl ? {29'h0, blkdbl_q, role_q} :
                     hit_xdly ? {16'h0, xdly_q} :
                     hit_uvd  ? {16'h0, uvdly_q} :
                     hit_stat ? status_w : 32'h0;
  wire bad_wr   = pwrite & hit_stat;

  // one wait-free access phase; read data loaded in setup
  always_ff @(posedge clock) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & (~mapped_w | bad_wr);
      if (setup_w) prdata_q <= pwrite ? 32'h0 : rd_w;
    end
  end

  // role and settings written by software
  always_ff @(posedge clock) begin
    if (srst) begin
      role_q   <= bts_pkg::ROLE_RST;
      blkdbl_q <= bts_pkg::BLKDBL_RST;
      xdly_q   <= bts_pkg::XDLY_RST;
      uvdly_q  <= bts_pkg::UVDLY_RST;
    end else if (access_w & pwrite) begin
      if (hit_ctrl) role_q   <= pwdata[bts_pkg::CTRL_ROLE_LSB +: 2];
      if (hit_ctrl) blkdbl_q <= pwdata[bts_pkg::CTRL_BLKDBL];
      if (hit_xdly) xdly_q   <= pwdata[15:0];
      if (hit_uvd)  uvdly_q  <= pwdata[15:0];
    end
  end

  // millisecond time base
  logic [16:0] presc_q;
  wire ms_tick = (presc_q == 17'(MS_CYCLES - 1));
  always_ff @(posedge clock) begin
    if (srst) presc_q <= 17'h0;
    else presc_q <= ms_tick ? 17'h0 : presc_q + 17'h1;
  end

  // role decode
  wire is_tie = (role_q == bts_pkg::ROLE_TIE);
  wire is_inc = (role_q == bts_pkg::ROLE_INC1) |
                (role_q == bts_pkg::ROLE_INC2);

  // undervoltage timing
  logic [15:0] uv_cnt_q;
  logic [15:0] xd_cnt_q;
  wire uv4_exp = srcdead & (uv_cnt_q >= uvdly_q);
  wire dbl_loss = srcdead & peeruv;

  // timed undervoltage accumulates whole milliseconds of source loss
  always_ff @(posedge clock) begin
    if (srst) uv_cnt_q <= 16'h0;
    else if (~srcdead) uv_cnt_q <= 16'h0;
    else if (ms_tick & ~uv4_exp) uv_cnt_q <= uv_cnt_q + 16'h1;
  end

  // other-source delay restarts while peer is low
  wire xd_run = (xd_cnt_q < xdly_q);
  always_ff @(posedge clock) begin
    if (srst) xd_cnt_q <= 16'h0;
    else if (peeruv) xd_cnt_q <= 16'h0;
    else if (ms_tick & xd_run) xd_cnt_q <= xd_cnt_q + 16'h1;
  end

  // incomer trip causes
  // double loss with blocking off still trips
  // double loss with blocking on holds breaker closed
  wire uv_trip   = uv4_exp & ~(dbl_loss & blkdbl_q);
  // undervoltage request withheld on double loss
  wire uv_req    = uv4_exp & ~dbl_loss;
  // lockout and source trip start a transfer
  wire inc_init  = is_inc & (lockout | srctrip | uv_trip);
  wire inc_req   = is_inc & (lockout | srctrip | uv_req);
  // bus tie trips after parallel with restored incomer
  wire tie_sel   = is_tie & seltrip & peercls & brk_cls;

  // transfer state
  logic req_q;
  logic open_q;
  logic cpend_q;
  logic pend1_q;
  logic pend2_q;
  logic close_q;
  logic out3_q;
  logic out4_q;
  logic out57_q;
  logic nr_q;

  // request follows own breaker and drops when it opens
  wire req_d = (req_q | inc_req) & brk_cls;

  // open latched until the breaker reads open
  wire open_d = (open_q | ropen_p | inc_init | tie_sel) & brk_cls;

  // manual close pending until closed or opened
  wire cpend_d = (cpend_q | rclose_p) & ~ropen_p & ~brk_cls & ~open_q;

  // bus tie remembers each incomer request
  wire pend1_d = is_tie & (pend1_q | req1_p) & ~ropen_p & ~brk_cls;
  wire pend2_d = is_tie & (pend2_q | req2_p) & ~ropen_p & ~brk_cls;

  // both sides live blocks close on request
  wire both_live = buslive & linelive;
  wire tie_auto  = ~both_live &
                   ((pend1_q & ~buslive) | (pend2_q & ~linelive));
  wire man_ok    = cpend_q & syncok & ~(is_inc & inc_init);
  wire close_d   = ~brk_cls & ~open_d & (man_ok | (is_tie & tie_auto));

  // peer undervoltage and its delay hold not ready
  wire nr_d      = is_inc & (peeruv | xd_run | blkxfer | peerblk | srcdead);
  // outputs 5 and 7 show ready and closed
  wire out57_d   = is_inc & brk_cls & ~nr_d;

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_q  <= '0;
      req_q   <= 1'b0;
      open_q  <= 1'b0;
      cpend_q <= 1'b0;
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
      close_q <= 1'b0;
      out3_q  <= 1'b0;
      out4_q  <= 1'b0;
      out57_q <= 1'b0;
      nr_q    <= 1'b0;
    end else begin
      prev_q  <= s;
      req_q   <= req_d;
      open_q  <= open_d;
      cpend_q <= cpend_d;
      pend1_q <= pend1_d;
      pend2_q <= pend2_d;
      close_q <= close_d;
      out3_q  <= is_inc & peeruv;
      // each incomer picks it up on loss of its own source
      out4_q  <= is_inc & srcdead;
      out57_q <= out57_d;
      nr_q    <= nr_d;
    end
  end

  // status word for software
  assign status_w = {16'h0, role_q, dbl_loss, uv4_exp, cpend_q,
                     pend2_q, pend1_q, nr_q, open_q, close_q,
                     out3_q, out4_q, out57_q, req_q, brk_cls, srcdead};

  // outputs straight from flip-flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign trip_out  = open_q;
  assign close_out = close_q;
  assign out3      = out3_q;
  assign out4      = out4_q;
  assign out5      = out57_q;
  assign out6      = req_q;
  assign out7      = out57_q;
  assign not_ready = nr_q;

  // assertions
  req_drop_a: assert property (@(posedge clock) disable iff (srst)
    !brk_cls |=> !out6)
    else $error("close request held with breaker open");

  lock_trip_a: assert property (@(posedge clock) disable iff (srst)
    (is_inc && lockout && brk_cls) |=> (trip_out && out6))
    else $error("lockout did not trip and request");

  src_trip_a: assert property (@(posedge clock) disable iff (srst)
    (is_inc && srctrip && brk_cls) |=> (trip_out && out6))
    else $error("source trip did not trip and request");

  live_block_a: assert property (@(posedge clock) disable iff (srst)
    (is_tie && both_live && !cpend_q) |=> !close_out)
    else $error("bus tie closed with both sides live");

  dead_bus_a: assert property (@(posedge clock) disable iff (srst)
    (is_tie && pend1_q && !buslive && !brk_cls && !open_d)
      |=> close_out)
    else $error("bus tie did not close on dead bus");

  dead_line_a: assert property (@(posedge clock) disable iff (srst)
    (is_tie && pend2_q && !linelive && !brk_cls && !open_d)
      |=> close_out)
    else $error("bus tie did not close on dead line");

  ropen_a: assert property (@(posedge clock) disable iff (srst)
    (ropen_p && brk_cls) |=> trip_out)
    else $error("remote open did not trip");

  sync_hold_a: assert property (@(posedge clock) disable iff (srst)
    (is_inc && !syncok) |=> !close_out)
    else $error("incomer closed without synchronism");

  uv_out4_a: assert property (@(posedge clock) disable iff (srst)
    is_inc && $rose(srcdead) |=> out4)
    else $error("output 4 late on source loss");

  peer_uv_a: assert property (@(posedge clock) disable iff (srst)
    (is_inc && peeruv) |=> (out3 && not_ready && !out5))
    else $error("peer undervoltage not shown");

  dbl_hold_a: assert property (@(posedge clock) disable iff (srst)
    (is_inc && dbl_loss && blkdbl_q && !lockout && !srctrip &&
     !ropen_p && !open_q) |=> !trip_out)
    else $error("double loss tripped while blocked");

  blk_xfer_a: assert property (@(posedge clock) disable iff (srst)
    (is_inc && blkxfer) |=> (not_ready && !out5 && !out7))
    else $error("block transfer not honoured");
endmodule : bts_top

// ==== bts_pkg.sv ====
// shared constants for the bus transfer scheme logic
package bts_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] XDLY_OFS    = 8'h04;
  localparam logic [7:0] UVDLY_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h0C;

  // control fields and reset values
  localparam int         CTRL_ROLE_LSB  = 0;
  localparam int         CTRL_BLKDBL    = 2;
  localparam logic [1:0] ROLE_RST       = 2'h0;
  localparam logic       BLKDBL_RST     = 1'b0;
  localparam logic [15:0] XDLY_RST      = 16'h0064;
  localparam logic [15:0] UVDLY_RST     = 16'h01F4;

  // unit roles
  localparam logic [1:0] ROLE_INC1 = 2'h0;
  localparam logic [1:0] ROLE_INC2 = 2'h1;
  localparam logic [1:0] ROLE_TIE  = 2'h2;

  // synchronised input vector positions
  localparam int NIN          = 16;
  localparam int IN_LOCKOUT   = 0;
  localparam int IN_SRCTRIP   = 1;
  localparam int IN_ROPEN     = 2;
  localparam int IN_RCLOSE    = 3;
  localparam int IN_BLKXFER   = 4;
  localparam int IN_SELTRIP   = 5;
  localparam int IN_BRKCLOSED = 6;
  localparam int IN_SRCDEAD   = 7;
  localparam int IN_BUSLIVE   = 8;
  localparam int IN_LINELIVE  = 9;
  localparam int IN_SYNCOK    = 10;
  localparam int IN_REQ1      = 11;
  localparam int IN_REQ2      = 12;
  localparam int IN_PEERUV    = 13;
  localparam int IN_PEERBLK   = 14;
  localparam int IN_PEERCLS   = 15;
endpackage : bts_pkg

// ==== bts_in_if.sv ====
// carrier for raw and synchronised discrete inputs
`timescale 1ns/1ns
interface bts_in_if;
  logic [bts_pkg::NIN-1:0] raw;
  logic [bts_pkg::NIN-1:0] sync;
  modport syncer (input raw, output sync);
  modport user   (output raw, input sync);
endinterface : bts_in_if

// ==== bts_sync.sv ====
// two-stage synchroniser bank for the discrete inputs
`timescale 1ns/1ns
module bts_sync (
  input  wire logic   clock,
  input  wire logic   srst,
  bts_in_if.syncer    pins
);
  logic [bts_pkg::NIN-1:0] meta_q;
  logic [bts_pkg::NIN-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins.raw;
      sync_q <= meta_q;
    end
  end

  assign pins.sync = sync_q;
endmodule : bts_sync

// ==== bts_brk_model.sv ====
// behavioural breaker answering the trip and close coils
`timescale 1ns/1ns
module bts_brk_model (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic trip,
  input  wire logic close,
  input  wire logic slow,
  output logic      closed
);
  logic [3:0] cnt_q;
  logic       closed_q;
  // the coil that would change state is the one that counts
  wire        busy = closed_q ? trip : close;
  wire [3:0]  lim  = slow ? 4'hB : 4'h1;
  assign closed = closed_q;
  // mechanism delay, prompt or slow
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q    <= 4'h0;
      closed_q <= 1'b0;
    end else if (!busy) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= lim) begin
      closed_q <= !closed_q;
      cnt_q    <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : bts_brk_model

// ==== tb_bus_transfer_scheme_logic.sv ====
// self-checking bench for the transfer scheme logic
`timescale 1ns/1ns
module tb_bus_transfer_scheme_logic;
  localparam int O7 = 0, O6 = 1, O5 = 2, O4 = 3, O3 = 4;
  localparam int CL = 5, TR = 6, NR = 7, BK = 8;
  logic        clock = 1'b0, srst = 1'b1, slow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] pins = 16'h0700;
  wire  [31:0] prdata;
  wire         pready, pslverr, trip_out, close_out, brk, not_ready;
  wire         out3, out4, out5, out6, out7;
  wire  [8:0]  outs = {brk, not_ready, trip_out, close_out, out3, out4,
                       out5, out6, out7};
  string       nm[9] = '{"out7", "out6", "out5", "out4", "out3", "close",
                         "trip", "not_ready", "brk"};
  logic [31:0] rst_v[3] = '{32'(bts_pkg::ROLE_RST) |
                            (32'(bts_pkg::BLKDBL_RST) << bts_pkg::CTRL_BLKDBL),
                            32'(bts_pkg::XDLY_RST), 32'(bts_pkg::UVDLY_RST)};
  logic [7:0]  rst_a[3] = '{bts_pkg::CTRL_OFS, bts_pkg::XDLY_OFS,
                            bts_pkg::UVDLY_OFS};
  int          fail_count = 0, check_count = 0;

  // short count for the millisecond base
  bts_top #(.MS_CYCLES(4)) dut (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .pins_in({pins[15:7], brk, pins[5:0]}), .trip_out(trip_out),
    .close_out(close_out), .out3(out3), .out4(out4), .out5(out5),
    .out6(out6), .out7(out7), .not_ready(not_ready)
  );
  bts_brk_model brk_m (
    .clock(clock), .srst(srst), .trip(trip_out), .close(close_out),
    .slow(slow), .closed(brk)
  );

  // 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // wait a bounded number of edges for one output level
  task automatic wt(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[i] !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(nm[i], {31'h0, v}, {31'h0, outs[i]});
  endtask : wt

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this step
    @(posedge clock);
  endtask : apb

  task automatic pulse(input int i);
    pins[i] <= 1'b1;
    tick(2);
    pins[i] <= 1'b0;
  endtask : pulse

  // close the breaker by a remote close pulse
  task automatic reclose;
    pulse(bts_pkg::IN_RCLOSE);
    wt(BK, 1'b1, 60);
  endtask : reclose

  // trip cause, synchroniser latency, request dropped on open
  task automatic trip_case(input int i);
    pins[i] <= 1'b1;
    tick(1);
    chk("sync_lat", 32'h0, {31'h0, trip_out});
    wt(TR, 1'b1, 6);
    chk("req6", 32'h1, {31'h0, out6});
    wt(BK, 1'b0, 40);
    wt(O6, 1'b0, 4);
    pins[i] <= 1'b0;
    tick(4);
    reclose();
  endtask : trip_case

  // watchdog
  initial begin
    tick(20000);
    fail_count++;
    results();
  end

  initial begin
    tick(5);
    srst <= 1'b0;
    tick(1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, rst_a[i], 32'h0);
      chk("reset_val", rst_v[i], rd);
      chk("ok_err", 32'h0, {31'h0, err});
    end
    apb(1'b1, bts_pkg::STATUS_OFS, 32'hFFFFFFFF);
    chk("ro_err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, bts_pkg::XDLY_OFS, 32'h2);
    apb(1'b1, bts_pkg::UVDLY_OFS, 32'h3);
    pins[bts_pkg::IN_SYNCOK] <= 1'b0;
    pulse(bts_pkg::IN_RCLOSE);
    tick(8);
    chk("held_close", 32'h0, {31'h0, close_out});
    pins[bts_pkg::IN_SYNCOK] <= 1'b1;
    wt(CL, 1'b1, 6);
    wt(BK, 1'b1, 20);
    wt(O5, 1'b1, 500);
    trip_case(bts_pkg::IN_LOCKOUT);
    slow <= 1'b1;
    trip_case(bts_pkg::IN_SRCTRIP);
    slow <= 1'b0;
    pulse(bts_pkg::IN_ROPEN);
    wt(TR, 1'b1, 6);
    wt(BK, 1'b0, 20);
    reclose();
    pins[bts_pkg::IN_PEERUV] <= 1'b1;
    wt(O3, 1'b1, 6);
    chk("nr_peer", 32'h1, {31'h0, not_ready});
    pins[bts_pkg::IN_PEERUV] <= 1'b0;
    tick(4);
    chk("nr_hold", 32'h1, {31'h0, not_ready});
    wt(NR, 1'b0, 20);
    pins[bts_pkg::IN_BLKXFER] <= 1'b1;
    wt(NR, 1'b1, 6);
    wt(O5, 1'b0, 2);
    wt(O7, 1'b0, 1);
    pins[bts_pkg::IN_BLKXFER] <= 1'b0;
    wt(O7, 1'b1, 40);
    // block transfer raised at the other incomer
    pins[bts_pkg::IN_PEERBLK] <= 1'b1;
    wt(NR, 1'b1, 6);
    wt(O5, 1'b0, 2);
    pins[bts_pkg::IN_PEERBLK] <= 1'b0;
    wt(O5, 1'b1, 40);
    pins[bts_pkg::IN_SRCDEAD] <= 1'b1;
    wt(O4, 1'b1, 4);
    chk("uv_early", 32'h0, {31'h0, trip_out});
    wt(TR, 1'b1, 30);
    chk("uv_req", 32'h1, {31'h0, out6});
    wt(BK, 1'b0, 20);
    pins[bts_pkg::IN_SRCDEAD] <= 1'b0;
    tick(4);
    reclose();
    for (int b = 1; b >= 0; b--) begin
      apb(1'b1, bts_pkg::CTRL_OFS, b ? 32'h4 : 32'h0);
      pins[bts_pkg::IN_SRCDEAD] <= 1'b1;
      pins[bts_pkg::IN_PEERUV]  <= 1'b1;
      wt(O4, 1'b1, 4);
      wt(NR, 1'b1, 4);
      if (b == 1) begin
        tick(30);
        chk("blk_trip", 32'h0, {31'h0, trip_out});
        chk("blk_brk", 32'h1, {31'h0, brk});
      end else begin
        wt(TR, 1'b1, 30);
        chk("dbl_req", 32'h0, {31'h0, out6});
        wt(BK, 1'b0, 20);
      end
      pins[bts_pkg::IN_SRCDEAD] <= 1'b0;
      pins[bts_pkg::IN_PEERUV]  <= 1'b0;
      tick(20);
    end
    // incomer two behaves as an incomer, idle role shows nothing
    apb(1'b1, bts_pkg::CTRL_OFS, 32'(bts_pkg::ROLE_INC2));
    pins[bts_pkg::IN_PEERUV] <= 1'b1;
    wt(O3, 1'b1, 6);
    apb(1'b1, bts_pkg::CTRL_OFS, 32'h3);
    wt(O3, 1'b0, 4);
    pins[bts_pkg::IN_PEERUV] <= 1'b0;
    apb(1'b1, bts_pkg::CTRL_OFS, 32'h2);
    apb(1'b0, bts_pkg::STATUS_OFS, 32'h0);
    chk("role", 32'h2, {30'h0, rd[15:14]});
    for (int r = 0; r < 2; r++) begin
      pulse(r ? bts_pkg::IN_REQ2 : bts_pkg::IN_REQ1);
      tick(8);
      chk("live_hold", 32'h0, {31'h0, close_out});
      pins[r ? bts_pkg::IN_LINELIVE : bts_pkg::IN_BUSLIVE] <= 1'b0;
      wt(CL, 1'b1, 6);
      wt(BK, 1'b1, 20);
      pins[bts_pkg::IN_BUSLIVE]  <= 1'b1;
      pins[bts_pkg::IN_LINELIVE] <= 1'b1;
      if (r == 0) begin
        pulse(bts_pkg::IN_ROPEN);
        wt(BK, 1'b0, 20);
      end
    end
    pins[bts_pkg::IN_SELTRIP] <= 1'b1;
    tick(8);
    chk("sel_wait", 32'h0, {31'h0, trip_out});
    pins[bts_pkg::IN_PEERCLS] <= 1'b1;
    wt(TR, 1'b1, 6);
    wt(BK, 1'b0, 20);
    results();
  end
endmodule : tb_bus_transfer_scheme_logic
